// ==== logic/apd_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

// Function
// (R1) With power-down enabled, idle counter starts counting when strobe activity stops.
// (R2) Fifteen idle external clock periods raise the power-down flag.
// (R3) The enable bit alone enables power-down entry.
// (R4) Strobe pulse, chip-select going low or reset high leave power-down.
// (R5) Power-down blocks address/data from memories and both logic arrays.
// (R6) Power-down deselects all memories.
// (R7) Logic arrays keep working in power-down; speed set only by fast-mode bit.
// (R8) Toggling unblocked logic-array inputs keep arrays awake, memories stay standby.
// (R9) Memories sleep when inputs static, wake for one update on a change.
// (R10) Chip-select high disables flash, SRAM and the I/O register page.
// (R11) Chip-select blocks no signals and leaves logic arrays enabled.
// (R12) Runtime-written blocking bits stop their signal reaching the logic arrays.
// (R13) Fast-mode bit resets to fast on; setting it turns fast mode off.
// (R14) External clock feeds macrocell flip-flops and the idle counter.
// (R15) Bit 1 of first power mode register enables automatic power-down.
// (R16) Power mode registers clear at power-up only, not on reset pulses.
// (R17) Blocking the external clock from arrays leaves the idle counter running.
// (R18) Each strobe edge clears the counter and the flag; the code clears them on rising strobe edges only.
// (R19) Disabled unit keeps counter cleared and flag low.
module pdu_unit
	import pdu_pkg::*;
(
	// Clock and power-up reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// Device pins
	input  wire pdu_pin_s     pins_i,
	// Memory select requests from the decode array
	input  wire logic         flash_req_i,
	input  wire logic         sram_req_i,
	input  wire logic         io_req_i,
	// Power mode register write port
	input  wire logic         pm_wr_i,
	input  wire logic         pm_sel_i,
	input  wire logic [7:0]   pm_wdata_i,
	// Power mode register contents
	output logic [7:0]        pm_first_o,
	output logic [7:0]        pm_third_o,
	// Logic array and memory side
	output pdu_la_s           la_o,
	output pdu_mem_s          mem_o,
	output logic              mem_standby_o,
	output logic              la_standby_o,
	output logic              fast_mode_o,
	// Power-down state
	output logic              powerdown_flag_o,
	output logic [IDLE_W-1:0] idle_count_o
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	pdu_pin_s sync1;
	pdu_pin_s sync2;
	pdu_pin_s sync3;
	pdu_pin_s next_sync1;
	pdu_pin_s next_sync2;
	pdu_pin_s next_sync3;

	always_comb begin
		next_sync1 = pins_i;
		next_sync2 = sync1;
		next_sync3 = sync2;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1 <= PIN_RESET;
			sync2 <= PIN_RESET;
			sync3 <= PIN_RESET;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	// ------------------------------------------------------------------
	// Pin events
	// ------------------------------------------------------------------
	logic strobe_edge;
	logic clk_tick;
	logic sel_fall;
	logic rst_high;
	logic wake;

	assign strobe_edge = sync2.strobe & ~sync3.strobe;
	assign clk_tick    = sync2.clk & ~sync3.clk;
	assign sel_fall    = ~sync2.sel_n & sync3.sel_n;
	assign rst_high    = sync2.rst;
	assign wake        = strobe_edge | sel_fall | rst_high; // R4

	// ------------------------------------------------------------------
	// Power mode registers
	// ------------------------------------------------------------------
	logic [7:0] next_pm_first;
	logic [7:0] next_pm_third;
	logic       auto_en;

	always_comb begin
		next_pm_first = pm_first_o;
		next_pm_third = pm_third_o;
		if (pm_wr_i && pm_sel_i == PM_SEL_FIRST) begin
			next_pm_first = pm_wdata_i & PM0_USED; // R12
		end
		if (pm_wr_i && pm_sel_i == PM_SEL_THIRD) begin
			next_pm_third = pm_wdata_i & PM2_USED; // R12
		end
	end

	// Only the power-up reset clears these; the reset pin does not
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pm_first_o <= PM_RESET; // R16
			pm_third_o <= PM_RESET; // R16
		end else begin
			pm_first_o <= next_pm_first;
			pm_third_o <= next_pm_third;
		end
	end

	assign auto_en     = pm_first_o[PM0_EN_BIT]; // R15 R3
	assign fast_mode_o = ~pm_first_o[PM0_TURBO_BIT]; // R13 R7

	// ------------------------------------------------------------------
	// Idle counter
	// ------------------------------------------------------------------
	logic cnt_clr;

	assign cnt_clr = ~auto_en | wake; // R18 R19

	// Tick is the raw pin clock, ahead of any array clock blocking
	pdu_idle_counter #(
		.W     (IDLE_W),
		.LIMIT (IDLE_LIMIT)
	) pdu_idle_counter_i (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.clr_i   (cnt_clr),
		.tick_i  (clk_tick), // R14 R17 R1
		.count_o (idle_count_o),
		.full_o  (powerdown_flag_o) // R2
	);

	// ------------------------------------------------------------------
	// Logic array and memory paths
	// ------------------------------------------------------------------
	pdu_la_s  next_la;
	pdu_mem_s next_mem;
	logic     sel_ok;
	logic     next_mem_standby;
	logic     next_la_standby;

	// Chip-select only gates the memories, never the arrays
	assign sel_ok = ~powerdown_flag_o & ~sync2.sel_n; // R6 R10 R11

	always_comb begin
		next_la = la_o;
		next_mem = mem_o;
		if (!powerdown_flag_o) begin
			next_la.ad = sync2.ad; // R5
			next_mem.ad = sync2.ad; // R5
		end
		for (int i = 0; i < 3; i++) begin
			if (!pm_third_o[PM2_CNTL0_BIT + i]) begin
				next_la.cntl[i] = sync2.cntl[i]; // R12
			end
		end
		if (!pm_third_o[PM2_STROBE_BIT]) begin
			next_la.strobe = sync2.strobe; // R12
		end
		if (!pm_third_o[PM2_DBE_BIT]) begin
			next_la.dbe = sync2.dbe; // R12
		end
		if (!pm_first_o[PM0_ARRCLK_BIT]) begin
			next_la.clk_array = sync2.clk; // R14
		end
		if (!pm_first_o[PM0_MCLK_BIT]) begin
			next_la.clk_mcell = sync2.clk; // R14
		end
		next_mem.flash_sel = flash_req_i & sel_ok; // R6 R10
		next_mem.sram_sel = sram_req_i & sel_ok; // R6 R10
		next_mem.io_sel = io_req_i & sel_ok; // R6 R10
		// Memories sleep unless they are selected and their view of the bus changes
		next_mem_standby = (next_mem == mem_o) | ~sel_ok; // R9
		// Arrays sleep only with fast mode off and no input moving
		next_la_standby = pm_first_o[PM0_TURBO_BIT] & (next_la == la_o); // R8 R7
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			la_o          <= LA_RESET;
			mem_o         <= MEM_RESET;
			mem_standby_o <= 1'b1;
			la_standby_o  <= 1'b0;
		end else begin
			la_o          <= next_la;
			mem_o         <= next_mem;
			mem_standby_o <= next_mem_standby;
			la_standby_o  <= next_la_standby;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_wake_event;
		strobe_edge || sel_fall || rst_high;
	endsequence

	sequence s_stays_awake;
		!powerdown_flag_o ##1 !powerdown_flag_o;
	endsequence

	a_wake_clears_pd: assert property (s_wake_event |=> s_stays_awake or // R4
		(!powerdown_flag_o ##1 1))
		else $error("power-down not left on wake event");

	a_strobe_clears_cnt: assert property (strobe_edge |=> idle_count_o == IDLE_RESET) // R18
		else $error("strobe edge did not clear idle counter");

	a_disabled_idle: assert property (!auto_en |=> // R19
		idle_count_o == IDLE_RESET && !powerdown_flag_o)
		else $error("disabled unit counted or flagged");

	a_pd_entry: assert property ($rose(powerdown_flag_o) |-> // R2
		$past(idle_count_o) == 4'hE && $past(clk_tick) && $past(auto_en))
		else $error("power-down entered without fifteen idle periods");

	a_mem_deselect: assert property (powerdown_flag_o |=> // R6
		!mem_o.flash_sel && !mem_o.sram_sel && !mem_o.io_sel)
		else $error("memory selected during power-down");

	a_bus_blocked: assert property (powerdown_flag_o |=> // R5
		$stable(la_o.ad) && $stable(mem_o.ad))
		else $error("bus passed during power-down");

	a_csel_blocks_mem: assert property (sync2.sel_n |=> // R10
		!mem_o.flash_sel && !mem_o.sram_sel && !mem_o.io_sel)
		else $error("memory selected with chip-select high");

	a_csel_no_block: assert property ((sync2.sel_n && !powerdown_flag_o) |=> // R11
		la_o.ad == $past(sync2.ad))
		else $error("chip-select blocked the logic arrays");

	a_block_strobe: assert property (pm_third_o[PM2_STROBE_BIT] |=> $stable(la_o.strobe)) // R12
		else $error("blocked strobe reached the logic arrays");

	a_regs_keep: assert property ((rst_high && !pm_wr_i) |=> // R16
		$stable(pm_first_o) && $stable(pm_third_o))
		else $error("reset pin changed power mode registers");

	a_clk_to_counter: assert property ((clk_tick && auto_en && !wake && !powerdown_flag_o // R17
		&& pm_first_o[PM0_ARRCLK_BIT] && pm_first_o[PM0_MCLK_BIT])
		|=> idle_count_o == $past(idle_count_o) + 4'h1)
		else $error("blocked array clock stopped the idle counter");

	a_mem_standby: assert property ($changed(mem_o) && $past(sel_ok) |-> !mem_standby_o) // R9
		else $error("memory stayed in standby across an input change");

	a_fast_keeps_awake: assert property (fast_mode_o |=> !la_standby_o) // R8
		else $error("arrays in standby with fast mode on");

	a_mem_sleep: assert property ($stable(mem_o) |-> mem_standby_o) // R9
		else $error("memory awake with static inputs");

	a_array_sleep: assert property (!$past(fast_mode_o) && $stable(la_o) |-> la_standby_o) // R8
		else $error("arrays awake with fast mode off and static inputs");

	a_block_cntl: assert property (pm_third_o[PM2_CNTL0_BIT] |=> $stable(la_o.cntl[0])) // R12
		else $error("blocked control line reached the logic arrays");

	a_block_dbe: assert property (pm_third_o[PM2_DBE_BIT] |=> $stable(la_o.dbe)) // R12
		else $error("blocked data enable reached the logic arrays");

	a_block_mclk: assert property (pm_first_o[PM0_MCLK_BIT] |=> $stable(la_o.clk_mcell)) // R14
		else $error("blocked macrocell clock reached the logic arrays");

	a_array_clk: assert property (!pm_first_o[PM0_ARRCLK_BIT] |=> // R14
		la_o.clk_array == $past(sync2.clk))
		else $error("array clock did not follow the pin clock");

	a_rst_pin_wake: assert property (rst_high |=> // R4
		idle_count_o == IDLE_RESET && !powerdown_flag_o)
		else $error("reset pin did not hold power-down clear");

	a_sel_passes: assert property ((!powerdown_flag_o && !sync2.sel_n) |=> // R10
		mem_o.flash_sel == $past(flash_req_i))
		else $error("selected memory request did not pass");

	a_pd_holds: assert property ((powerdown_flag_o && !wake && auto_en) |=> // R2
		powerdown_flag_o && idle_count_o == IDLE_LIMIT)
		else $error("power-down left without a wake event");

endmodule

`default_nettype wire

// ==== common/apd_pkg.sv ====
`default_nettype none

package pdu_pkg;

	// ------------------------------------------------------------------
	// Idle counter
	// ------------------------------------------------------------------
	localparam int         IDLE_W     = 4;
	localparam logic [3:0] IDLE_LIMIT = 4'hF;
	localparam logic [3:0] IDLE_RESET = 4'h0;

	// ------------------------------------------------------------------
	// Power mode registers: bit positions and values after power-up
	// ------------------------------------------------------------------
	localparam logic       PM_SEL_FIRST   = 1'b0;
	localparam logic       PM_SEL_THIRD   = 1'b1;
	localparam int         PM0_EN_BIT     = 1;
	localparam int         PM0_TURBO_BIT  = 3;
	localparam int         PM0_ARRCLK_BIT = 4;
	localparam int         PM0_MCLK_BIT   = 5;
	localparam int         PM2_CNTL0_BIT  = 2;
	localparam int         PM2_STROBE_BIT = 5;
	localparam int         PM2_DBE_BIT    = 6;
	localparam logic [7:0] PM0_USED       = 8'h3A;
	localparam logic [7:0] PM2_USED       = 8'h7C;
	localparam logic [7:0] PM_RESET       = 8'h00;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ad;
		logic [2:0] cntl;
		logic       strobe;
		logic       dbe;
		logic       clk;
		logic       sel_n;
		logic       rst;
	} pdu_pin_s;

	typedef struct packed {
		logic [7:0] ad;
		logic [2:0] cntl;
		logic       strobe;
		logic       dbe;
		logic       clk_array;
		logic       clk_mcell;
	} pdu_la_s;

	typedef struct packed {
		logic [7:0] ad;
		logic       flash_sel;
		logic       sram_sel;
		logic       io_sel;
	} pdu_mem_s;

	localparam pdu_pin_s PIN_RESET = '0;
	localparam pdu_la_s  LA_RESET  = '0;
	localparam pdu_mem_s MEM_RESET = '0;

endpackage

`default_nettype wire

// ==== logic/apd_idle_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module pdu_idle_counter
	import pdu_pkg::*;
#(
	parameter int         W     = IDLE_W,
	parameter logic [3:0] LIMIT = IDLE_LIMIT
) (
	// Clock and power-up reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// Control
	input  wire logic         clr_i,
	input  wire logic         tick_i,
	// State
	output logic [W-1:0]      count_o,
	output logic              full_o
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (W != 4 || LIMIT == 4'h0) begin : g_bad
		$error("pdu_idle_counter: unsupported width or limit");
	end

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	logic [W-1:0] next_count;
	logic         next_full;

	always_comb begin
		next_count = count_o;
		if (clr_i) begin
			next_count = IDLE_RESET;
		end else if (tick_i && !full_o) begin
			next_count = count_o + 4'h1;
		end
		next_full = (next_count == LIMIT);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_o <= IDLE_RESET;
			full_o  <= 1'b0;
		end else begin
			count_o <= next_count;
			full_o  <= next_full;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_full_means_limit: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
		full_o |-> count_o == LIMIT)
		else $error("flag high without full count");

	a_tick_steps_once: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
		(tick_i && !clr_i && !full_o) |=> count_o == $past(count_o) + 4'h1)
		else $error("idle counter did not advance on a clock period");

endmodule

`default_nettype wire

// ==== tb/apd_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Bus master side: oscillator and strobe
// ----------------------------------------
module pdu_mcu_model #(
	parameter int HALF = 5
) (
	// System side
	input  wire logic clk_i,
	input  wire logic pulse_i,
	// Pins
	output logic      ext_clk_o,
	output logic      strobe_o,
	output var int    rises_o
);
	int div = 0;
	int hi  = 0;

	initial begin
		ext_clk_o = 1'b0;
		strobe_o = 1'b0;
		rises_o = 0;
	end

	// Free-running oscillator; rises tallied since the last strobe
	always @(negedge clk_i) begin
		div <= (div == HALF - 1) ? 0 : div + 1;
		if (div == HALF - 1) begin
			ext_clk_o <= ~ext_clk_o;
			if (!ext_clk_o)
				rises_o <= rises_o + 1;
		end
		if (pulse_i) begin
			hi <= 2;
			rises_o <= 0;
		end else if (hi > 0)
			hi <= hi - 1;
		strobe_o <= pulse_i || hi > 1;
	end
endmodule

`default_nettype wire

// ==== tb/apd_unit_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: got %0h want %0h", $time, g, e); end end

module pdu_unit_tb;
	import pdu_pkg::*;
	logic              clk_i       = 1'b0;
	logic              rstn_i      = 1'b0;
	pdu_pin_s          drv         = PIN_RESET;
	pdu_pin_s          pins_i;
	logic              flash_req_i = 1'b0;
	logic              sram_req_i  = 1'b0;
	logic              io_req_i    = 1'b0;
	logic              pm_wr_i     = 1'b0;
	logic              pm_sel_i    = 1'b0;
	logic [7:0]        pm_wdata_i  = 8'h00;
	logic [7:0]        pm_first_o, pm_third_o, sv_ad, sv_md;
	pdu_la_s           la_o;
	pdu_mem_s          mem_o;
	logic              mem_standby_o, la_standby_o, fast_mode_o, powerdown_flag_o;
	logic [IDLE_W-1:0] idle_count_o;
	logic              pulse       = 1'b0;
	logic              ext_clk, strobe, hold;
	logic [1:0]        clk_hold;
	int                rises, k;
	int                mismatches  = 0;
	int                checks      = 0;
	logic [31:0]       rng         = 32'h00013EC8;

	always #5 clk_i = ~clk_i;

	always_comb begin
		pins_i = drv;
		pins_i.strobe = strobe;
		pins_i.clk = ext_clk;
	end

	pdu_mcu_model pdu_mcu_model_i (.clk_i, .pulse_i(pulse), .ext_clk_o(ext_clk),
		.strobe_o(strobe), .rises_o(rises));
	pdu_unit pdu_unit_i (.clk_i, .rstn_i, .pins_i, .flash_req_i, .sram_req_i, .io_req_i,
		.pm_wr_i, .pm_sel_i, .pm_wdata_i, .pm_first_o, .pm_third_o, .la_o, .mem_o,
		.mem_standby_o, .la_standby_o, .fast_mode_o, .powerdown_flag_o, .idle_count_o);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic logic [3:0] exp_cnt(input int n);
		return (n >= 15) ? IDLE_LIMIT : 4'(n);
	endfunction

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	task automatic wait_rises(input int n);
		for (int i = 0; i < 400 && rises != n; i++)
			cyc(1);
		if (rises != n) begin
			mismatches++;
			$display("wrong value at %0t: wait ran out", $time);
			test_done;
		end
	endtask

	task automatic wait_flag;
		for (int i = 0; i < 400 && powerdown_flag_o !== 1'b1; i++)
			cyc(1);
		`CHK(powerdown_flag_o, 1'b1)
		if (powerdown_flag_o !== 1'b1)
			test_done;
	endtask

	task automatic strobe_pulse;
		wait_rises(rises + 1);
		pulse <= 1'b1;
		cyc(1);
		pulse <= 1'b0;
		cyc(6);
	endtask

	task automatic pm_write(input logic sel, input logic [7:0] d);
		pm_wr_i <= 1'b1;
		pm_sel_i <= sel;
		pm_wdata_i <= d;
		cyc(1);
		pm_wr_i <= 1'b0;
		cyc(1);
	endtask

	task automatic rnd;
		rng = xs(rng);
		drv.ad <= rng[7:0];
		drv.cntl <= rng[10:8];
		drv.dbe <= rng[11];
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		cyc(3);
		`CHK(fast_mode_o, 1'b1)
		`CHK(pm_first_o, 8'h00)
		rstn_i <= 1'b1;
		cyc(2);
		pm_write(PM_SEL_FIRST, 8'hFF);
		`CHK(pm_first_o, 8'h3A)
		`CHK(fast_mode_o, 1'b0)
		`CHK(la_standby_o, 1'b1)
		pm_write(PM_SEL_THIRD, 8'hFF);
		`CHK(pm_third_o, 8'h7C)
		pm_write(PM_SEL_THIRD, 8'h00);
		pm_write(PM_SEL_FIRST, 8'h00);
		`CHK(la_standby_o, 1'b0)
		cyc(40);
		`CHK(idle_count_o, 4'h0)
		`CHK(powerdown_flag_o, 1'b0)
		tend("registers");
		pm_write(PM_SEL_FIRST, 8'h32);
		strobe_pulse();
		clk_hold = {la_o.clk_array, la_o.clk_mcell};
		for (k = 1; k <= 16; k++) begin
			rnd();
			wait_rises(k);
			cyc(6);
			`CHK(idle_count_o, exp_cnt(k))
			`CHK(powerdown_flag_o, k >= 15)
			`CHK({la_o.clk_array, la_o.clk_mcell}, clk_hold)
		end
		tend("count");
		sv_ad = la_o.ad;
		sv_md = mem_o.ad;
		{flash_req_i, sram_req_i, io_req_i} <= 3'h7;
		drv.ad <= ~sv_ad;
		cyc(5);
		`CHK(la_o.ad, sv_ad)
		`CHK(mem_o.ad, sv_md)
		`CHK({mem_o.flash_sel, mem_o.sram_sel, mem_o.io_sel}, 3'h0)
		`CHK(mem_standby_o, 1'b1)
		`CHK(fast_mode_o, 1'b1)
		strobe_pulse();
		`CHK(powerdown_flag_o, 1'b0)
		`CHK(idle_count_o, 4'h0)
		`CHK(mem_o.ad, drv.ad)
		`CHK(mem_o.flash_sel, 1'b1)
		wait_rises(6);
		cyc(6);
		`CHK(idle_count_o, 4'h6)
		`CHK(mem_standby_o, 1'b1)
		strobe_pulse();
		`CHK(idle_count_o, 4'h0)
		tend("powerdown");
		drv.sel_n <= 1'b1;
		rnd();
		cyc(5);
		`CHK({mem_o.flash_sel, mem_o.sram_sel, mem_o.io_sel}, 3'h0)
		`CHK(la_o.ad, drv.ad)
		drv.sel_n <= 1'b0;
		wait_flag();
		drv.sel_n <= 1'b1;
		cyc(3);
		drv.sel_n <= 1'b0;
		cyc(5);
		`CHK(powerdown_flag_o, 1'b0)
		wait_flag();
		drv.rst <= 1'b1;
		cyc(5);
		`CHK(powerdown_flag_o, 1'b0)
		cyc(30);
		`CHK(idle_count_o, 4'h0)
		`CHK(pm_first_o, 8'h32)
		drv.rst <= 1'b0;
		tend("wake");
		strobe_pulse();
		pm_write(PM_SEL_THIRD, 8'h04);
		hold = la_o.cntl[0];
		drv.cntl <= {la_o.cntl[2:1] ^ 2'h3, ~hold};
		cyc(5);
		`CHK(la_o.cntl, {drv.cntl[2:1], hold})
		rstn_i <= 1'b0;
		cyc(1);
		`CHK(pm_first_o, 8'h00)
		rstn_i <= 1'b1;
		tend("blocking");
		test_done;
	end
endmodule

`default_nettype wire
